// [rtl/ideu_pkg.sv]
/*
 package for the interrupt and debug exception unit: register offsets,
 status word bit positions, vector offsets and reset values.
 assumes a 32-bit AHB-Lite slave port and one core clock.
*/
package ideu_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_STATUS  = 8'h00;
	localparam logic [7:0] OFF_RET_PC  = 8'h04;
	localparam logic [7:0] OFF_VBASE   = 8'h08;
	localparam logic [7:0] OFF_DEBUG   = 8'h0C;
	localparam logic [7:0] OFF_BKPT0   = 8'h10;
	localparam logic [7:0] OFF_BKPT1   = 8'h14;
	localparam logic [7:0] OFF_WATCH0  = 8'h18;
	localparam logic [7:0] OFF_WATCH1  = 8'h1C;
	localparam logic [7:0] OFF_VECTOR  = 8'h20;
	// status word bit positions
	localparam int SB_SOFT   = 0;
	localparam int SB_EXT    = 1;
	localparam int SB_TMR    = 2;
	localparam int SB_INSVC  = 3;
	localparam int SB_GIE    = 5;
	localparam int SB_SAVED  = 6;
	localparam int SB_STEP   = 10;
	localparam int SB_DBERR  = 14;
	localparam int SB_FBERR  = 15;
	localparam int SB_CODE   = 16;
	localparam int SB_MASK   = 20;
	localparam int SB_LINES  = 26;
	// debug register bit positions
	localparam int DB_BKPT0_ON  = 0;
	localparam int DB_BKPT1_ON  = 1;
	localparam int DB_WATCH0_ON = 2;
	localparam int DB_WATCH1_ON = 3;
	localparam int DB_W0_HIT    = 4;
	localparam int DB_W1_HIT    = 5;
	localparam int DB_BKPT_MATCHED    = 6;
	// vector offsets and base reset value
	localparam logic [7:0]  VEC_RESET = 8'h00;
	localparam logic [7:0]  VEC_SOFT  = 8'h04;
	localparam logic [7:0]  VEC_TMR   = 8'h08;
	localparam logic [7:0]  VEC_EXT   = 8'h0C;
	localparam logic [7:0]  VEC_BERR  = 8'h10;
	localparam logic [23:0] VBASE_RST = 24'h000000;
	localparam int VBASE_WR_CYCLES = 2;
	localparam int ENTRY_MAX_CYCLES = 4;
	localparam int NUM_EXT = 6;
	localparam logic [31:0] STATUS_RST = 32'h00000000;
	typedef enum logic [4:0] {
		C_NONE = 5'h01,
		C_SOFT = 5'h02,
		C_TMR  = 5'h04,
		C_EXT  = 5'h08,
		C_BERR = 5'h10
	} ideu_cause_t;
endpackage

// [rtl/ideu_core.sv]
/*
 interrupt and debug exception unit: vector formation, in-service flags,
 software/timer/external/bus-error entry, single step, breakpoints, watchpoints.
 assumes the pipeline pulses its events on ref_clk and follows take_trap.
*/
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
// What this block does
// - vector is base upper 24 plus offset
// - vector base write completes in two cycles
// - five vectors, offsets 0,4,8,12,16; offsets 4 to 16 configurable, reset fixed at address zero
// - entry copies in-service to saved, sets in-service
// - return restores in-service from saved, clears saved
// - branch to handler within four cycles
// - timer/external ignored unless enabled, not in-service
// - reset non-maskable, starts at address zero
// - soft trap: offset 4, cause, code bits
// - soft trap taken even while in service
// - timer trap: offset 8, timer cause set
// - six external lines, masked, globally gated
// - level external request sets cause and line
// - line 0 highest, line 5 lowest priority
// - bus error non-maskable, fetch/data flag
// - bus error return address may be imprecise
// - step armed by return, traps each instruction
// - stepping saves next address, blocks timer/external
// - breakpoint compare at register read stage
// - breakpoint trap before instruction, own address
// - watchpoint trap after access, hit flag set
`timescale 1ns/10ps
module ideu_core
	import ideu_pkg::*;
#(
	parameter logic [23:0] VBASE_INIT  = ideu_pkg::VBASE_RST,
	parameter logic [7:0]  SOFT_VEC    = ideu_pkg::VEC_SOFT,
	parameter logic [7:0]  TMR_VEC     = ideu_pkg::VEC_TMR,
	parameter logic [7:0]  EXT_VEC     = ideu_pkg::VEC_EXT,
	parameter logic [7:0]  BERR_VEC    = ideu_pkg::VEC_BERR,
	parameter bit          BKPT_FEATURE_CFG  = 1'b1,
	parameter bit          WATCH_FEATURE_CFG = 1'b1
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [ideu_pkg::NUM_EXT-1:0] ext_irq_line,
	input  wire logic        bus_err_in,
	input  wire logic        bus_err_fetch,
	input  wire logic        tmr_expired,
	input  wire logic        soft_trap_op,
	input  wire logic [3:0]  soft_trap_code,
	input  wire logic        return_op,
	input  wire logic        instr_retired,
	input  wire logic [31:0] next_pc,
	input  wire logic [31:0] reg_read_stage_pc,
	input  wire logic        reg_read_stage_valid,
	input  wire logic        ls_done,
	input  wire logic [31:0] ls_addr,
	output logic             take_trap,
	output logic [31:0]      trap_target,
	output logic [31:0]      return_pc,
	output logic [31:0]      status_word
);
	import ideu_pkg::*;

	// the priority picker and line fields are sized for exactly six lines
	if (NUM_EXT != 6) begin : g_ext_chk
		$error("six external lines only");
	end

	logic [31:0] ext_s1, ext_s2;
	logic [1:0]  berr_s;
	logic [1:0]  bfetch_s;
	logic [23:0] vbase;
	logic [23:0] vbase_pend;
	logic        vbase_busy;
	logic [31:0] dbg;
	logic [31:0] bkpt_addr0, bkpt_addr1, watch_addr0, watch_addr1;
	logic        step_live;
	logic [7:0]  a_off;
	logic        a_wr, a_act;
	logic [2:0]  pend_cnt;
	logic        pend_any;

	// external lines and bus error come from other logic domains
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ext_s1 <= 32'h00000000;
			ext_s2 <= 32'h00000000;
			berr_s <= 2'h0;
			bfetch_s <= 2'h0;
		end else begin
			ext_s1 <= {26'h0000000, ext_irq_line};
			ext_s2 <= ext_s1;
			berr_s <= {berr_s[0], bus_err_in};
			// qualifier rides the same two stages so it stays aligned with the error
			bfetch_s <= {bfetch_s[0], bus_err_fetch};
		end
	end

	function automatic logic [5:0] first_line(input logic [5:0] req);
		logic [5:0] r;
		r = 6'h00;
		for (int i = NUM_EXT - 1; i >= 0; i--) begin
			if (req[i])
				r = 6'h01 << i;
		end
		return r;
	endfunction

	function automatic logic [31:0] vec_addr(input logic [23:0] b, input logic [7:0] o);
		return {b, o};
	endfunction

	// cause selection
	logic [5:0]  ext_req;
	logic        mask_ok;
	logic        bkpt_hit0, bkpt_hit1, watch_hit0, watch_hit1;
	ideu_cause_t cause;
	logic [31:0] next_status;

	always_comb begin
		mask_ok = status_word[SB_GIE] && !status_word[SB_INSVC] && !step_live;
		ext_req = ext_s2[5:0] & ~status_word[SB_MASK +: NUM_EXT];
		bkpt_hit0 = BKPT_FEATURE_CFG && dbg[DB_BKPT0_ON] && reg_read_stage_valid
			&& reg_read_stage_pc == bkpt_addr0;
		bkpt_hit1 = BKPT_FEATURE_CFG && dbg[DB_BKPT1_ON] && reg_read_stage_valid
			&& reg_read_stage_pc == bkpt_addr1;
		watch_hit0 = WATCH_FEATURE_CFG && dbg[DB_WATCH0_ON] && ls_done && ls_addr == watch_addr0;
		watch_hit1 = WATCH_FEATURE_CFG && dbg[DB_WATCH1_ON] && ls_done && ls_addr == watch_addr1;
		// bus error first: non-maskable, software trap ignores in-service
		if (berr_s[1])
			cause = C_BERR;
		else if (soft_trap_op || bkpt_hit0 || bkpt_hit1 || watch_hit0 || watch_hit1
			|| (step_live && instr_retired))
			cause = C_SOFT;
		else if (mask_ok && tmr_expired)
			cause = C_TMR;
		else if (mask_ok && |ext_req)
			cause = C_EXT;
		else
			cause = C_NONE;
	end

	always_comb begin
		next_status = status_word;
		if (cause != C_NONE) begin
			next_status[SB_SAVED] = status_word[SB_INSVC];
			next_status[SB_INSVC] = 1'b1;
		end
		case (cause)
			C_SOFT: begin
				next_status[SB_SOFT] = soft_trap_op;
				if (soft_trap_op)
					next_status[SB_CODE +: 4] = soft_trap_code;
				else
					next_status[SB_CODE +: 8] = 8'hFF;
			end
			C_TMR:  next_status[SB_TMR] = 1'b1;
			C_EXT: begin
				next_status[SB_EXT] = 1'b1;
				next_status[SB_LINES +: NUM_EXT] = first_line(ext_req);
			end
			C_BERR: begin
				next_status[SB_FBERR] = bfetch_s[1];
				next_status[SB_DBERR] = !bfetch_s[1];
			end
			default: begin
				if (return_op) begin
					next_status[SB_INSVC] = status_word[SB_SAVED];
					next_status[SB_SAVED] = 1'b0;
				end
			end
		endcase
	end

	// bus address phase capture
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			a_act <= 1'b0;
			a_wr  <= 1'b0;
			a_off <= 8'h00;
		end else if (hready) begin
			a_act <= hsel && htrans[1];
			a_wr  <= hwrite;
			a_off <= haddr[7:0];
		end
	end

	// always OKAY, still registered so every output leaves a flop
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	// no wait states: hreadyout low in reset, high from the first clock after it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			hreadyout <= 1'b0;
		else
			hreadyout <= 1'b1;
	end

	logic wr_status;
	assign wr_status = a_act && a_wr && a_off == OFF_STATUS;

	// status word: hardware entry beats a software write in the same cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			status_word <= STATUS_RST;
		else if (cause != C_NONE || return_op)
			status_word <= next_status;
		else if (wr_status)
			status_word <= hwdata;
	end

	// single step arms on the return that follows the flag being set
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			step_live <= 1'b0;
		else if (!status_word[SB_STEP])
			step_live <= 1'b0;
		else if (return_op)
			step_live <= 1'b1;
	end

	// base write lands on the second cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			vbase      <= VBASE_INIT;
			vbase_pend <= 24'h000000;
			vbase_busy <= 1'b0;
		end else begin
			vbase_busy <= a_act && a_wr && a_off == OFF_VBASE;
			if (a_act && a_wr && a_off == OFF_VBASE)
				vbase_pend <= hwdata[31:8];
			if (vbase_busy)
				vbase <= vbase_pend;
		end
	end

	// debug register; hit flags set win over software clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dbg         <= 32'h00000000;
			bkpt_addr0  <= 32'h00000000;
			bkpt_addr1  <= 32'h00000000;
			watch_addr0 <= 32'h00000000;
			watch_addr1 <= 32'h00000000;
		end else begin
			if (a_act && a_wr) begin
				if (a_off == OFF_DEBUG)
					dbg <= {25'h0000000, hwdata[6:0]};
				else if (a_off == OFF_BKPT0)
					bkpt_addr0 <= hwdata;
				else if (a_off == OFF_BKPT1)
					bkpt_addr1 <= hwdata;
				else if (a_off == OFF_WATCH0)
					watch_addr0 <= hwdata;
				else if (a_off == OFF_WATCH1)
					watch_addr1 <= hwdata;
			end
			if (cause == C_SOFT && (bkpt_hit0 || bkpt_hit1))
				dbg[DB_BKPT_MATCHED] <= 1'b1;
			if (cause == C_SOFT && watch_hit0)
				dbg[DB_W0_HIT] <= 1'b1;
			if (cause == C_SOFT && watch_hit1)
				dbg[DB_W1_HIT] <= 1'b1;
		end
	end

	// trap outputs; the entry is registered, one cycle after detection
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			take_trap   <= 1'b1;
			trap_target <= 32'h00000000;
			return_pc   <= 32'h00000000;
		end else begin
			take_trap <= cause != C_NONE;
			case (cause)
				C_SOFT: trap_target <= vec_addr(vbase, SOFT_VEC);
				C_TMR:  trap_target <= vec_addr(vbase, TMR_VEC);
				C_EXT:  trap_target <= vec_addr(vbase, EXT_VEC);
				C_BERR: trap_target <= vec_addr(vbase, BERR_VEC);
				default: trap_target <= trap_target;
			endcase
			// breakpoint returns to its own instruction, others to the next one
			if (cause == C_SOFT && (bkpt_hit0 || bkpt_hit1) && !soft_trap_op)
				return_pc <= reg_read_stage_pc;
			else if (cause != C_NONE)
				return_pc <= next_pc;
			else if (a_act && a_wr && a_off == OFF_RET_PC)
				return_pc <= hwdata;
		end
	end

	// read data
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			hrdata <= 32'h00000000;
		else if (hready && hsel && htrans[1] && !hwrite) begin
			if (haddr[7:0] == OFF_STATUS)
				hrdata <= status_word;
			else if (haddr[7:0] == OFF_RET_PC)
				hrdata <= return_pc;
			else if (haddr[7:0] == OFF_VBASE)
				hrdata <= {vbase, 8'h00};
			else if (haddr[7:0] == OFF_DEBUG)
				hrdata <= dbg;
			else if (haddr[7:0] == OFF_BKPT0)
				hrdata <= bkpt_addr0;
			else if (haddr[7:0] == OFF_BKPT1)
				hrdata <= bkpt_addr1;
			else if (haddr[7:0] == OFF_WATCH0)
				hrdata <= watch_addr0;
			else if (haddr[7:0] == OFF_WATCH1)
				hrdata <= watch_addr1;
			else if (haddr[7:0] == OFF_VECTOR)
				hrdata <= trap_target;
			else
				hrdata <= 32'h00000000;
		end
	end

	// helper: cycles since a pending cause appeared without entry
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pend_cnt <= 3'h0;
			pend_any <= 1'b0;
		end else begin
			pend_any <= cause != C_NONE;
			pend_cnt <= (cause != C_NONE && !take_trap) ? pend_cnt + 3'h1 : 3'h0;
		end
	end

	entry_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
		pend_cnt < 3'h4) else $error("entry late");
	saved_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
		cause != C_NONE |=> status_word[SB_INSVC] && status_word[SB_SAVED] == $past(status_word[SB_INSVC]))
		else $error("in-service not saved");
	ret_restore_a: assert property (@(posedge ref_clk) disable iff (rst)
		cause == C_NONE && return_op |=> !status_word[SB_SAVED]
		&& status_word[SB_INSVC] == $past(status_word[SB_SAVED])) else $error("return restore bad");
	masked_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
		!status_word[SB_GIE] |-> cause != C_TMR && cause != C_EXT) else $error("masked irq taken");
	soft_vec_a: assert property (@(posedge ref_clk) disable iff (rst)
		soft_trap_op && !berr_s[1] |=> take_trap && trap_target == {vbase, SOFT_VEC}
		&& status_word[SB_SOFT]) else $error("soft trap wrong");
	ext_prio_a: assert property (@(posedge ref_clk) disable iff (rst)
		cause == C_EXT && ext_req[0] |=> status_word[SB_LINES +: NUM_EXT] == 6'h01) else $error("line order");
	berr_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
		berr_s[1] |=> trap_target[7:0] == BERR_VEC && status_word[SB_FBERR] != status_word[SB_DBERR])
		else $error("bus error entry bad");
	bkpt_pc_a: assert property (@(posedge ref_clk) disable iff (rst)
		cause == C_SOFT && bkpt_hit0 && !soft_trap_op |=> return_pc == $past(reg_read_stage_pc)
		&& dbg[DB_BKPT_MATCHED]) else $error("breakpoint pc bad");
	vbase_lat_a: assert property (@(posedge ref_clk) disable iff (rst)
		a_act && a_wr && a_off == OFF_VBASE |-> ##2 vbase == $past(hwdata[31:8], 2)) else $error("base late");
	tmr_vec_a: assert property (@(posedge ref_clk) disable iff (rst)
		cause == C_TMR |=> take_trap && trap_target == {$past(vbase), TMR_VEC} && status_word[SB_TMR])
		else $error("timer entry bad");
	ext_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		cause == C_EXT |=> (status_word[SB_LINES +: NUM_EXT] & status_word[SB_MASK +: NUM_EXT]) == 6'h00)
		else $error("masked line served");
	step_trap_a: assert property (@(posedge ref_clk) disable iff (rst)
		step_live && instr_retired && !berr_s[1] && !soft_trap_op |=> take_trap && !status_word[SB_SOFT]
		&& status_word[SB_CODE +: 8] == 8'hFF) else $error("step trap bad");
	watch_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
		cause == C_SOFT && watch_hit1 |=> dbg[DB_W1_HIT]) else $error("watch flag missing");
endmodule

// [tb/ideu_irq_src.sv]
/*
 far-side model: six level interrupt sources and the system bus error line.
 assumes commands from the bench on ref_clk and the unit's entry outputs.
*/
`timescale 1ns/10ps
module ideu_irq_src
	import ideu_pkg::*;
(
	input  wire logic                         ref_clk,
	input  wire logic                         rst,
	input  wire logic [ideu_pkg::NUM_EXT-1:0] raise,
	input  wire logic                         berr_go,
	input  wire logic                         berr_kind,
	input  wire logic                         take_trap,
	input  wire logic [31:0]                  status_word,
	output logic      [ideu_pkg::NUM_EXT-1:0] ext_irq_line,
	output logic                              bus_err_in,
	output logic                              bus_err_fetch
);
	// a line stays up until its entry is seen, never dropped early
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ext_irq_line <= 6'h00;
		end else begin
			ext_irq_line <= (ext_irq_line | raise) & ~(take_trap ? status_word[31:26] : 6'h00);
		end
	end
	// qualifier flips once released so a stale value is never trusted
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bus_err_in <= 1'b0;
			bus_err_fetch <= 1'b0;
		end else if (berr_go) begin
			bus_err_in <= 1'b1;
			bus_err_fetch <= berr_kind;
		end else if (bus_err_in && take_trap && (status_word[SB_DBERR] || status_word[SB_FBERR])) begin
			bus_err_in <= 1'b0;
			bus_err_fetch <= ~bus_err_fetch;
		end
	end
endmodule

// [tb/testbench.sv]
/*
 self-checking bench for the exception unit: bus tasks, event pulses, checks.
 assumes the irq source model beside the unit and one 100 MHz clock.
*/
`timescale 1ns/10ps
module testbench;
	import ideu_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0, hwrite = 1'b0, hresp, hreadyout;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	wire logic   hready;
	logic        soft_trap_op = 1'b0, tmr_expired = 1'b0, return_op = 1'b0, instr_retired = 1'b0;
	logic        reg_read_stage_valid = 1'b0, ls_done = 1'b0, berr_go = 1'b0, berr_kind = 1'b0;
	logic [3:0]  soft_trap_code = 4'h0;
	logic [31:0] next_pc = 32'h0, reg_read_stage_pc = 32'h0, ls_addr = 32'h0;
	logic [5:0]  raise = 6'h00, ext_irq_line;
	logic        bus_err_in, bus_err_fetch, take_trap;
	logic [31:0] trap_target, return_pc, status_word;
	logic [23:0] vb = VBASE_RST;
	int          bad_count = 0, check_count = 0;
	assign hready = hreadyout;
	always #5 ref_clk = ~ref_clk;
	ideu_core dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_irq_line(ext_irq_line), .bus_err_in(bus_err_in),
		.bus_err_fetch(bus_err_fetch), .tmr_expired(tmr_expired), .soft_trap_op(soft_trap_op),
		.soft_trap_code(soft_trap_code), .return_op(return_op), .instr_retired(instr_retired),
		.next_pc(next_pc), .reg_read_stage_pc(reg_read_stage_pc),
		.reg_read_stage_valid(reg_read_stage_valid), .ls_done(ls_done), .ls_addr(ls_addr),
		.take_trap(take_trap), .trap_target(trap_target), .return_pc(return_pc), .status_word(status_word));
	ideu_irq_src src (.ref_clk(ref_clk), .rst(rst), .raise(raise), .berr_go(berr_go),
		.berr_kind(berr_kind), .take_trap(take_trap), .status_word(status_word),
		.ext_irq_line(ext_irq_line), .bus_err_in(bus_err_in), .bus_err_fetch(bus_err_fetch));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// no fixed latency assumed: the bench timeout ends a stuck wait
	task automatic ahb(input logic wr, input logic [7:0] off, input logic [31:0] wd);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, off};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge ref_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hready !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic rdc(input string nm, input logic [7:0] off, input logic [31:0] exp);
		ahb(1'b0, off, 32'h0);
		chk(nm, exp, rd);
	endtask
	task automatic pulse(input int k);
		@(posedge ref_clk);
		case (k)
			0: soft_trap_op <= 1'b1;
			1: tmr_expired <= 1'b1;
			2: return_op <= 1'b1;
			3: instr_retired <= 1'b1;
			4: reg_read_stage_valid <= 1'b1;
			default: ls_done <= 1'b1;
		endcase
		@(posedge ref_clk);
		{soft_trap_op, tmr_expired, return_op, instr_retired, reg_read_stage_valid, ls_done} <= 6'h00;
	endtask
	task automatic trap(input int lim, input logic [7:0] off, input logic exp_hit);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < lim && !hit; i++) begin
			if (i > 0) @(posedge ref_clk);
			#1;
			hit = (take_trap === 1'b1);
		end
		chk("take_trap", {31'h0, exp_hit}, {31'h0, hit});
		if (exp_hit && hit) chk("trap_target", {vb, off}, trap_target);
	endtask
	task automatic berr(input logic kind);
		@(posedge ref_clk);
		berr_go <= 1'b1;
		berr_kind <= kind;
		@(posedge ref_clk);
		berr_go <= 1'b0;
	endtask
	// settle synchronised lines before clearing, else the old cause re-enters
	task automatic clr(input logic [31:0] s);
		repeat (4) @(posedge ref_clk);
		ahb(1'b1, OFF_STATUS, s);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		conclude;
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		#1;
		chk("reset take_trap", 32'h1, {31'h0, take_trap});
		chk("reset target", 32'h0, trap_target);
		@(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rdc("status", OFF_STATUS, STATUS_RST);
		rdc("unmapped", 8'h40, 32'h0);
		$display("test reset done");
		next_pc <= 32'h100;
		soft_trap_code <= 4'hA;
		pulse(0);
		trap(4, VEC_SOFT, 1'b1);
		chk("soft status", 32'h000A0009, status_word);
		chk("soft ret pc", 32'h100, return_pc);
		next_pc <= 32'h200;
		soft_trap_code <= 4'h5;
		pulse(0);
		trap(4, VEC_SOFT, 1'b1);
		chk("nested status", 32'h00050049, status_word);
		chk("nested ret pc", 32'h200, return_pc);
		pulse(2);
		#1;
		chk("return flags", 32'h8, status_word & 32'h48);
		pulse(2);
		#1;
		chk("return flags", 32'h0, status_word & 32'h48);
		vb = 24'hABCDEF;
		ahb(1'b1, OFF_VBASE, {vb, 8'h00});
		repeat (2) @(posedge ref_clk);
		rdc("vbase", OFF_VBASE, {vb, 8'h00});
		pulse(0);
		trap(4, VEC_SOFT, 1'b1);
		rdc("last vector", OFF_VECTOR, {vb, VEC_SOFT});
		$display("test soft trap done");
		clr(32'h0);
		pulse(1);
		trap(6, VEC_TMR, 1'b0);
		clr(32'h20);
		pulse(1);
		trap(4, VEC_TMR, 1'b1);
		chk("timer status", 32'h2C, status_word & 32'hFF);
		pulse(1);
		trap(6, VEC_TMR, 1'b0);
		$display("test timer done");
		clr(32'h20);
		@(posedge ref_clk);
		raise <= 6'h0A;
		@(posedge ref_clk);
		raise <= 6'h00;
		trap(8, VEC_EXT, 1'b1);
		chk("ext status", 32'h0800002A, status_word & 32'hFC00002B);
		clr(32'h20 | (32'h1 << (SB_MASK + 3)));
		trap(6, VEC_EXT, 1'b0);
		clr(32'h20);
		trap(8, VEC_EXT, 1'b1);
		chk("ext line3", 32'h20000000, status_word & 32'hFC000000);
		clr(32'h20);
		@(posedge ref_clk);
		raise <= 6'h21;
		@(posedge ref_clk);
		raise <= 6'h00;
		trap(8, VEC_EXT, 1'b1);
		chk("ext line0", 32'h04000000, status_word & 32'hFC000000);
		clr(32'h20);
		trap(8, VEC_EXT, 1'b1);
		chk("ext line5", 32'h80000000, status_word & 32'hFC000000);
		$display("test external done");
		clr(32'h0);
		berr(1'b0);
		trap(8, VEC_BERR, 1'b1);
		chk("data berr", 32'h4000, status_word & 32'hC000);
		clr(32'h0);
		berr(1'b1);
		trap(8, VEC_BERR, 1'b1);
		chk("fetch berr", 32'h8000, status_word & 32'hC000);
		$display("test bus error done");
		clr(32'h0);
		ahb(1'b1, OFF_BKPT0, 32'h300);
		ahb(1'b1, OFF_DEBUG, 32'h1);
		reg_read_stage_pc <= 32'h300;
		pulse(4);
		trap(4, VEC_SOFT, 1'b1);
		chk("bkpt ret pc", 32'h300, return_pc);
		chk("bkpt status", 32'h00FF0000, status_word & 32'h00FF0001);
		rdc("bkpt hit", OFF_DEBUG, 32'h41);
		ahb(1'b1, OFF_DEBUG, 32'h0);
		clr(32'h0);
		ahb(1'b1, OFF_WATCH1, 32'h400);
		ahb(1'b1, OFF_DEBUG, 32'h8);
		ls_addr <= 32'h400;
		pulse(5);
		trap(4, VEC_SOFT, 1'b1);
		rdc("watch hit", OFF_DEBUG, 32'h28);
		ahb(1'b1, OFF_DEBUG, 32'h0);
		$display("test debug compare done");
		clr(32'h400);
		pulse(3);
		trap(4, VEC_SOFT, 1'b0);
		pulse(2);
		next_pc <= 32'h500;
		pulse(3);
		trap(4, VEC_SOFT, 1'b1);
		chk("step status", 32'h00FF0000, status_word & 32'h00FF0001);
		chk("step ret pc", 32'h500, return_pc);
		$display("test single step done");
		conclude;
	end
endmodule
